//--- bench/elec_irq_sink.sv
// Behavioural model of the interrupt controller and wake-up logic beyond the block.
`timescale 1ns/1ps
`default_nettype none
module elec_irq_sink
(
	input wire logic clock,
	input wire logic reset_n,
	input wire logic [23:0] irqReq,
	input wire logic wakeupReq,
	input wire logic [23:0] channelEnable,
	output logic [23:0] servicedLines,
	output logic awake
);
	// ------------------------------------------------------------
	// Service and wake-up
	// ------------------------------------------------------------
	// enabled channels only
	// A request on a closed channel is held off, as the real controller would.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			servicedLines <= 24'h000000;
		else
			servicedLines <= irqReq & channelEnable;
	end
	// wake on request
	// The core sleeps until the combined request shows.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			awake <= 1'b0;
		else
			awake <= wakeupReq;
	end
endmodule : elec_irq_sink
`default_nettype wire

//--- bench/external_line_event_controller_bench.sv
// Self-checking bench for the line event controller.
`timescale 1ns/1ps
`default_nettype none
module external_line_event_controller_bench
	import elec_pkg::*;
;
	// ------------------------------------------------------------
	// Stimulus signals and notes of expected results
	// ------------------------------------------------------------
	logic clock = 1'b0;
	logic reset_n, awValid, wValid, bValid, bReady, arValid, rValid, rReady;
	logic awReady, wReady, arReady, wakeupReq, awake;
	logic [7:0] awAddr, arAddr;
	logic [31:0] wData, rData;
	logic [3:0] wStrb;
	logic [1:0] bResp, rResp;
	logic [23:0] lineIn, irqReq, eventPulse, servicedLines;
	logic [33:0] rdQ[$], wrQ[$], evQ[$]; // Oldest note first.
	int miscompares = 0;
	int samplesChecked = 0;
	int cycles = 0;
	localparam logic [23:0] CHAN_EN = 24'hffff7f; // Channel seven stays closed.
	always #12.5 clock = ~clock;
	elec_line_event_ctrl dut (.clock(clock), .reset_n(reset_n),
		.s_axi_awaddr(awAddr), .s_axi_awvalid(awValid), .s_axi_awready(awReady),
		.s_axi_wdata(wData), .s_axi_wstrb(wStrb), .s_axi_wvalid(wValid), .s_axi_wready(wReady),
		.s_axi_bresp(bResp), .s_axi_bvalid(bValid), .s_axi_bready(bReady),
		.s_axi_araddr(arAddr), .s_axi_arvalid(arValid), .s_axi_arready(arReady),
		.s_axi_rdata(rData), .s_axi_rresp(rResp), .s_axi_rvalid(rValid), .s_axi_rready(rReady),
		// pins and internal sources wired straight to lineIn
		.pinLines(lineIn[15:0]), .supplyVoltageMonitor(lineIn[16]), .clockAlarm(lineIn[17]),
		.stampTamperOscFail(lineIn[18]), .clockWakeupTimer(lineIn[19]),
		.lowPowerTimerWakeup(lineIn[20]), .comparatorOne(lineIn[21]),
		.comparatorTwo(lineIn[22]), .comparatorThree(lineIn[23]),
		.irqReq(irqReq), .eventPulse(eventPulse), .wakeupReq(wakeupReq));
	elec_irq_sink sink (.clock(clock), .reset_n(reset_n), .irqReq(irqReq),
		.wakeupReq(wakeupReq), .channelEnable(CHAN_EN), .servicedLines(servicedLines),
		.awake(awake));
	// ------------------------------------------------------------
	// Shared tasks
	// ------------------------------------------------------------
	task check(input string nm, input logic [33:0] seen, input logic [33:0] exp);
		samplesChecked++;
		if (seen !== exp)
		begin
			miscompares++;
			$display("ERROR %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task print_verdict();
		if (miscompares == 0 && samplesChecked > 0)
			$display("STATUS OK");
		else
			$display("STATUS NOT OK");
		$finish;
	endtask : print_verdict
	// Offers address and data together and releases each once taken.
	task axiWrite(input logic [7:0] a, input logic [31:0] d, input logic [3:0] s,
		input logic [1:0] r);
		logic awOpen, wOpen, seenAw, seenW, seenB;
		wrQ.push_back({32'h0, r});
		awAddr <= a;
		wData <= d;
		wStrb <= s;
		awValid <= 1'b1;
		wValid <= 1'b1;
		bReady <= 1'b1;
		awOpen = 1'b1;
		wOpen = 1'b1;
		seenB = 1'b0;
		while (awOpen || wOpen)
		begin
			@(negedge clock);
			seenAw = awReady;
			seenW = wReady;
			@(posedge clock);
			if (awOpen && seenAw)
			begin
				awValid <= 1'b0;
				awOpen = 1'b0;
			end
			if (wOpen && seenW)
			begin
				wValid <= 1'b0;
				wOpen = 1'b0;
			end
		end
		while (!seenB)
		begin
			@(negedge clock);
			seenB = bValid;
			@(posedge clock);
		end
		bReady <= 1'b0;
		@(posedge clock);
	endtask : axiWrite
	task axiRead(input logic [7:0] a, input logic [33:0] exp);
		logic seenAr, seenR;
		rdQ.push_back(exp);
		arAddr <= a;
		arValid <= 1'b1;
		rReady <= 1'b1;
		seenAr = 1'b0;
		seenR = 1'b0;
		while (!seenAr)
		begin
			@(negedge clock);
			seenAr = arReady;
			@(posedge clock);
		end
		arValid <= 1'b0;
		while (!seenR)
		begin
			@(negedge clock);
			seenR = rValid;
			@(posedge clock);
		end
		rReady <= 1'b0;
		@(posedge clock);
	endtask : axiRead
	// Opens one line with the given masks and edge enables.
	task setLine(input logic [23:0] b, input logic im, input logic em, input logic ri,
		input logic fa);
		axiWrite(IRQ_MASK_OFF, {8'h0, im ? b : 24'h0}, 4'hf, RESP_OKAY);
		axiWrite(EVENT_MASK_OFF, {8'h0, em ? b : 24'h0}, 4'hf, RESP_OKAY);
		axiWrite(RISE_EN_OFF, {8'h0, ri ? b : 24'h0}, 4'hf, RESP_OKAY);
		axiWrite(FALL_EN_OFF, {8'h0, fa ? b : 24'h0}, 4'hf, RESP_OKAY);
	endtask : setLine
	// Rise, then fall, one line, with the mix of settings picked by its number.
	task lineTest(input int n);
		logic [23:0] b;
		logic ri, fa, im, em;
		b = 24'h1 << n;
		ri = (n % 3 != 1);
		fa = (n % 3 != 0);
		im = (n % 4 != 1);
		em = (n % 4 != 2);
		setLine(b, im, em, ri, fa);
		if (ri && em)
			evQ.push_back({10'h0, b});
		lineIn[n] <= 1'b1;
		repeat (6) @(posedge clock);
		if (fa && em)
			evQ.push_back({10'h0, b});
		lineIn[n] <= 1'b0;
		repeat (6) @(posedge clock);
		@(negedge clock);
		check("irqReq", {10'h0, irqReq}, {10'h0, im ? b : 24'h0});
		check("serviced", {10'h0, servicedLines}, {10'h0, (im && n != 7) ? b : 24'h0});
		check("awake", {33'h0, awake}, {33'h0, im});
		@(posedge clock);
		axiRead(PENDING_OFF, {RESP_OKAY, 8'h0, im ? b : 24'h0});
		axiWrite(PENDING_OFF, {8'h0, ~b}, 4'hf, RESP_OKAY);
		axiRead(PENDING_OFF, {RESP_OKAY, 8'h0, im ? b : 24'h0});
		axiWrite(PENDING_OFF, {8'h0, b}, 4'hf, RESP_OKAY);
		axiRead(PENDING_OFF, {RESP_OKAY, 32'h0});
		@(negedge clock);
		check("irqCleared", {10'h0, irqReq}, 34'h0);
		@(posedge clock);
	endtask : lineTest
	task softTest(input int n);
		logic [23:0] b;
		b = 24'h1 << n;
		setLine(b, 1'b1, 1'b1, 1'b1, 1'b0);
		evQ.push_back({10'h0, b});
		axiWrite(SOFT_TRIG_OFF, {8'h0, b}, 4'hf, RESP_OKAY);
		axiRead(SOFT_TRIG_OFF, {RESP_OKAY, 8'h0, b});
		axiWrite(SOFT_TRIG_OFF, {8'h0, b}, 4'hf, RESP_OKAY);
		axiRead(PENDING_OFF, {RESP_OKAY, 8'h0, b});
		axiWrite(PENDING_OFF, {8'h0, b}, 4'hf, RESP_OKAY);
		axiRead(SOFT_TRIG_OFF, {RESP_OKAY, 32'h0});
	endtask : softTest
	// ------------------------------------------------------------
	// Output watcher, timeout and main sequence
	// ------------------------------------------------------------
	// Handshakes and pulses are judged mid-cycle, where all outputs have settled.
	always @(negedge clock)
	begin
		if (rValid && rReady)
			check("readAnswer", {rResp, rData}, rdQ.size() ? rdQ.pop_front() : '1);
		if (bValid && bReady)
			check("writeAnswer", {32'h0, bResp}, wrQ.size() ? wrQ.pop_front() : '1);
		if (eventPulse !== 24'h0)
			check("eventPulse", {10'h0, eventPulse}, evQ.size() ? evQ.pop_front() : '1);
	end
	// A hang counts as a mismatch.
	always @(posedge clock)
	begin
		cycles++;
		if (cycles == 20000)
		begin
			miscompares++;
			print_verdict();
		end
	end
	initial
	begin
		logic [31:0] d;
		{reset_n, awValid, wValid, bReady, arValid, rReady} = 6'h00;
		{awAddr, arAddr, wData, wStrb, lineIn} = '0;
		void'($urandom(74));
		repeat (6) @(posedge clock);
		reset_n <= 1'b1;
		@(posedge clock);
		for (int i = 0; i < 6; i++)
			axiRead(8'(i * 4), {RESP_OKAY, 32'h0});
		axiRead(8'h18, {RESP_SLVERR, 32'h0});
		axiRead(8'h06, {RESP_SLVERR, 32'h0});
		axiWrite(8'h1c, 32'hffffffff, 4'hf, RESP_SLVERR);
		for (int i = 0; i < 4; i++)
		begin
			d = $urandom;
			axiWrite(8'(i * 4), d, 4'hf, RESP_OKAY);
			axiRead(8'(i * 4), {RESP_OKAY, 8'h0, d[23:0]});
		end
		axiWrite(IRQ_MASK_OFF, 32'h0, 4'hf, RESP_OKAY);
		axiWrite(IRQ_MASK_OFF, 32'hffffffff, 4'ha, RESP_OKAY);
		axiRead(IRQ_MASK_OFF, {RESP_OKAY, 32'h00ff00});
		for (int n = 0; n < NUM_LINES; n++)
			lineTest(n);
		softTest(5);
		softTest(20);
		repeat (8) @(posedge clock);
		check("notesLeft", 34'(evQ.size() + rdQ.size() + wrQ.size()), 34'h0);
		print_verdict();
	end
endmodule : external_line_event_controller_bench
`default_nettype wire

//--- verilog/elec_line_event_ctrl.sv
// Edge-triggered interrupt and event controller for 24 lines with an AXI4-Lite register port.
//
// Contract
// - 24 lines: 16 pins, 8 internal sources.
// - Per-line rising and falling edge enables.
// - Interrupt request passes only when mask is one.
// - Unmasked enabled edge sets pending, raises request.
// - Writing one clears pending; zero does nothing.
// - Event output gated only by event mask.
// - Event gives one pulse, never sets pending.
// - Soft trigger write acts like hardware edge.
// - Per-line requests go to vectored interrupt controller.
// - Per-line flags and settings are independent.
// - Internal lines 16..23 wired to named sources.
// - Enabled event or interrupt wakes the processor.
// - Soft bit reading zero, written one, sets pending.
// - Edge enables gate both paths; all reset zero.
//
// Implementation choices: the register addresses and the AXI4-Lite register port.
`timescale 1ns/1ps
`default_nettype none
module elec_line_event_ctrl
	import elec_pkg::*;
(
	input wire logic clock,
	input wire logic reset_n,
	// AXI4-Lite slave port.
	input wire logic [7:0] s_axi_awaddr,
	input wire logic s_axi_awvalid,
	output logic s_axi_awready,
	input wire logic [31:0] s_axi_wdata,
	input wire logic [3:0] s_axi_wstrb,
	input wire logic s_axi_wvalid,
	output logic s_axi_wready,
	output logic [1:0] s_axi_bresp,
	output logic s_axi_bvalid,
	input wire logic s_axi_bready,
	input wire logic [7:0] s_axi_araddr,
	input wire logic s_axi_arvalid,
	output logic s_axi_arready,
	output logic [31:0] s_axi_rdata,
	output logic [1:0] s_axi_rresp,
	output logic s_axi_rvalid,
	input wire logic s_axi_rready,
	// Line sources, all asynchronous to clock.
	input wire logic [15:0] pinLines,
	input wire logic supplyVoltageMonitor,
	input wire logic clockAlarm,
	input wire logic stampTamperOscFail,
	input wire logic clockWakeupTimer,
	input wire logic lowPowerTimerWakeup,
	input wire logic comparatorOne,
	input wire logic comparatorTwo,
	input wire logic comparatorThree,
	// Outputs toward the vectored interrupt controller and wake-up logic.
	output logic [23:0] irqReq,
	output logic [23:0] eventPulse,
	output logic wakeupReq
);
	// ----------------------------------------------------------------
	// Elaboration checks
	// ----------------------------------------------------------------
	// The register layout fixes the split of pin and internal lines.
	if (NUM_PIN_LINES + NUM_INT_LINES != NUM_LINES)
	begin : g_badSplit
		$error("Line split does not match the register width.");
	end
	// ----------------------------------------------------------------
	// Helpers
	// ----------------------------------------------------------------
	// Expands the byte strobes to a 24-bit mask of written bits.
	function automatic logic [23:0] strobeMask(input logic [3:0] strb);
		strobeMask = {{8{strb[2]}}, {8{strb[1]}}, {8{strb[0]}}};
	endfunction : strobeMask

	// True when the offset is one of the six mapped registers.
	function automatic logic isMapped(input logic [7:0] off);
		isMapped = (off[1:0] == 2'h0) && (off <= PENDING_OFF);
	endfunction : isMapped
	// ----------------------------------------------------------------
	// State
	// ----------------------------------------------------------------
	logic [23:0] irqMask_r, eventMask_r; // One opens the interrupt or event path of a line.
	logic [23:0] riseEn_r, fallEn_r; // Rising and falling edge enables.
	logic [23:0] softTrig_r; // Soft trigger bits as read back.
	logic [23:0] pending_r; // Sticky pending flags.
	logic [23:0] sync1_r, sync2_r; // First and second synchroniser stages.
	logic [23:0] prev_r; // Previous synchronised sample.
	logic [23:0] eventPulse_r; // Registered event pulses.
	logic [23:0] rawLines; // Concatenated sources.
	logic [23:0] hwEdge; // Enabled edges seen this cycle.
	logic [23:0] trig; // Hardware or soft trigger this cycle.
	logic [23:0] pendClr; // Pending bits written with one.
	logic [23:0] softSet; // Soft trigger bits newly written with one.
	logic awHeld_r, wHeld_r; // Write address and write data captured.
	logic [7:0] awAddr_r; // Captured write address.
	logic [31:0] wData_r; // Captured write data.
	logic [3:0] wStrb_r; // Captured write strobes.
	logic bValid_r, rValid_r; // Write response and read data pending.
	logic [1:0] bResp_r, rResp_r; // Write and read response codes.
	logic [31:0] rData_r; // Read data.
	logic doWrite; // Register write happens this cycle.
	logic [23:0] wrBits; // Data bits that the strobes let through.
	// ----------------------------------------------------------------
	// Source wiring and edge detection
	// ----------------------------------------------------------------
	// internal source order
	assign rawLines = {comparatorThree, comparatorTwo, comparatorOne, lowPowerTimerWakeup,
		clockWakeupTimer, stampTamperOscFail, clockAlarm, supplyVoltageMonitor, pinLines};

	// Two flops bring each line into the clock domain; a third keeps the old sample.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			sync1_r <= LINE_RESET;
			sync2_r <= LINE_RESET;
			prev_r <= LINE_RESET;
		end
		else
		begin
			sync1_r <= rawLines;
			sync2_r <= sync1_r;
			prev_r <= sync2_r;
		end
	end

	assign hwEdge = (sync2_r & ~prev_r & riseEn_r) | (~sync2_r & prev_r & fallEn_r);
	// ----------------------------------------------------------------
	// Register write decode
	// ----------------------------------------------------------------
	assign doWrite = awHeld_r && wHeld_r && !bValid_r;
	assign wrBits = wData_r[23:0] & strobeMask(wStrb_r);
	assign pendClr = (doWrite && awAddr_r == PENDING_OFF) ? wrBits : LINE_RESET;
	// only a bit reading zero fires
	assign softSet = (doWrite && awAddr_r == SOFT_TRIG_OFF) ? (wrBits & ~softTrig_r) : LINE_RESET;
	assign trig = hwEdge | softSet;

	// Configuration registers honour byte strobes; the upper byte is reserved.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			irqMask_r <= LINE_RESET;
			eventMask_r <= LINE_RESET;
			riseEn_r <= LINE_RESET;
			fallEn_r <= LINE_RESET;
		end
		else if (doWrite)
		begin
			case (awAddr_r)
				IRQ_MASK_OFF: irqMask_r <= (irqMask_r & ~strobeMask(wStrb_r)) | wrBits;
				EVENT_MASK_OFF: eventMask_r <= (eventMask_r & ~strobeMask(wStrb_r)) | wrBits;
				RISE_EN_OFF: riseEn_r <= (riseEn_r & ~strobeMask(wStrb_r)) | wrBits;
				FALL_EN_OFF: fallEn_r <= (fallEn_r & ~strobeMask(wStrb_r)) | wrBits;
				default: ; // Other offsets have their own processes.
			endcase
		end
	end

	// Soft trigger bits stay set until the line's pending flag is cleared, so a
	// second write of one cannot fire again before software has served the first.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			softTrig_r <= LINE_RESET;
		else
			softTrig_r <= (softTrig_r & ~pendClr) | softSet;
	end
	// ----------------------------------------------------------------
	// Pending flags and outputs
	// ----------------------------------------------------------------
	// A trigger in the same cycle as a clear wins, so no edge is lost.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			pending_r <= LINE_RESET;
		else
			pending_r <= (pending_r & ~pendClr) | (trig & irqMask_r);
	end

	// Event pulses last one cycle and never touch the pending flags.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
			eventPulse_r <= LINE_RESET;
		else
			eventPulse_r <= trig & eventMask_r;
	end

	assign irqReq = pending_r & irqMask_r;
	assign eventPulse = eventPulse_r;
	assign wakeupReq = (|irqReq) | (|eventPulse_r);
	// ----------------------------------------------------------------
	// AXI4-Lite write channels
	// ----------------------------------------------------------------
	assign s_axi_awready = !awHeld_r && !bValid_r;
	assign s_axi_wready = !wHeld_r && !bValid_r;
	assign s_axi_bvalid = bValid_r;
	assign s_axi_bresp = bResp_r;

	// Address and data are taken in either order and held until both are here.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			awHeld_r <= 1'b0;
			wHeld_r <= 1'b0;
			awAddr_r <= 8'h00;
			wData_r <= 32'h00000000;
			wStrb_r <= 4'h0;
			bValid_r <= 1'b0;
			bResp_r <= RESP_OKAY;
		end
		else
		begin
			if (s_axi_awvalid && s_axi_awready)
			begin
				awHeld_r <= 1'b1;
				awAddr_r <= s_axi_awaddr;
			end
			if (s_axi_wvalid && s_axi_wready)
			begin
				wHeld_r <= 1'b1;
				wData_r <= s_axi_wdata;
				wStrb_r <= s_axi_wstrb;
			end
			if (doWrite)
			begin
				// Response rises with the register update.
				awHeld_r <= 1'b0;
				wHeld_r <= 1'b0;
				bValid_r <= 1'b1;
				bResp_r <= isMapped(awAddr_r) ? RESP_OKAY : RESP_SLVERR;
			end
			else if (bValid_r && s_axi_bready)
				bValid_r <= 1'b0;
		end
	end
	// ----------------------------------------------------------------
	// AXI4-Lite read channels
	// ----------------------------------------------------------------
	assign s_axi_arready = !rValid_r;
	assign s_axi_rvalid = rValid_r;
	assign s_axi_rdata = rData_r;
	assign s_axi_rresp = rResp_r;

	// Reads have no side effects; reserved bits read zero.
	always_ff @(posedge clock)
	begin
		if (!reset_n)
		begin
			rValid_r <= 1'b0;
			rData_r <= 32'h00000000;
			rResp_r <= RESP_OKAY;
		end
		else if (s_axi_arvalid && s_axi_arready)
		begin
			rValid_r <= 1'b1;
			rResp_r <= isMapped(s_axi_araddr) ? RESP_OKAY : RESP_SLVERR;
			case (s_axi_araddr)
				IRQ_MASK_OFF: rData_r <= {8'h00, irqMask_r};
				EVENT_MASK_OFF: rData_r <= {8'h00, eventMask_r};
				RISE_EN_OFF: rData_r <= {8'h00, riseEn_r};
				FALL_EN_OFF: rData_r <= {8'h00, fallEn_r};
				SOFT_TRIG_OFF: rData_r <= {8'h00, softTrig_r};
				PENDING_OFF: rData_r <= {8'h00, pending_r};
				default: rData_r <= 32'h00000000;
			endcase
		end
		else if (rValid_r && s_axi_rready)
			rValid_r <= 1'b0;
	end
	// ----------------------------------------------------------------
	// Assertions
	// ----------------------------------------------------------------
	default clocking cb @(posedge clock); endclocking
	default disable iff (!reset_n);
	property p_maskGate; (irqReq & ~irqMask_r) == LINE_RESET; endproperty
	a_maskGate: assert property (p_maskGate) else $error("Masked line drives a request.");
	property p_pendSet;
		|(trig & irqMask_r) |=> ((pending_r & $past(trig & irqMask_r)) == $past(trig & irqMask_r));
	endproperty
	a_pendSet: assert property (p_pendSet) else $error("Trigger did not set pending.");
	property p_pendClr;
		|(pendClr & ~trig) |=> ((pending_r & $past(pendClr & ~trig)) == LINE_RESET);
	endproperty
	a_pendClr: assert property (p_pendClr) else $error("Cleared pending flag stayed set.");
	property p_evtGate; 1'b1 |=> eventPulse == ($past(trig) & $past(eventMask_r)); endproperty
	a_evtGate: assert property (p_evtGate) else $error("Event pulse not tied to mask.");
	property p_evtNoPend;
		|(trig & eventMask_r & ~irqMask_r) |=>
			((pending_r & ~$past(pending_r) & $past(trig & ~irqMask_r)) == LINE_RESET);
	endproperty
	a_evtNoPend: assert property (p_evtNoPend) else $error("Event set a pending flag.");
	property p_softFire;
		|softSet |=> (eventPulse | pending_r) != LINE_RESET ||
			$past((irqMask_r | eventMask_r) & softSet) == LINE_RESET;
	endproperty
	a_softFire: assert property (p_softFire) else $error("Soft trigger had no effect.");
	property p_softOnce; |softSet |=> ((softSet & $past(softSet)) == LINE_RESET); endproperty
	a_softOnce: assert property (p_softOnce) else $error("Soft trigger fired twice.");
	property p_riseDetect; |(sync2_r & ~prev_r & riseEn_r) |-> |trig; endproperty
	a_riseDetect: assert property (p_riseDetect) else $error("Enabled rising edge missed.");
	property p_noEdgeNoTrig;
		(riseEn_r | fallEn_r) == LINE_RESET |-> hwEdge == LINE_RESET;
	endproperty
	a_noEdgeNoTrig: assert property (p_noEdgeNoTrig) else $error("Edge while disabled.");
	property p_wake; |(trig & (irqMask_r | eventMask_r)) |=> wakeupReq; endproperty
	a_wake: assert property (p_wake) else $error("Trigger did not raise wake-up.");
	property p_bHold;
		s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp);
	endproperty
	a_bHold: assert property (p_bHold) else $error("Write response dropped early.");
	c_pendSet: cover property (|(pending_r & ~$past(pending_r)));
	c_event: cover property (|eventPulse);
	c_soft: cover property (|softSet ##1 |pending_r);
	c_badRead: cover property (s_axi_rvalid && s_axi_rresp == RESP_SLVERR);
endmodule : elec_line_event_ctrl
`default_nettype wire

//--- verilog/elec_pkg.sv
// Package holding the register map, field widths and reset values of the line event controller.
`default_nettype none
package elec_pkg;
	// ----------------------------------------------------------------
	// Line counts
	// ----------------------------------------------------------------
	localparam int NUM_LINES = 24; // Total lines, one bit each per register.
	localparam int NUM_PIN_LINES = 16; // Lines 0 to 15 come from port pins.
	localparam int NUM_INT_LINES = 8; // Lines 16 to 23 come from on-chip modules.
	// ----------------------------------------------------------------
	// Register byte offsets on the AXI4-Lite port
	// ----------------------------------------------------------------
	localparam logic [7:0] IRQ_MASK_OFF = 8'h00; // irq_mask_reg.
	localparam logic [7:0] EVENT_MASK_OFF = 8'h04; // event_mask_reg.
	localparam logic [7:0] RISE_EN_OFF = 8'h08; // rise_edge_enable_reg.
	localparam logic [7:0] FALL_EN_OFF = 8'h0c; // fall_edge_enable_reg.
	localparam logic [7:0] SOFT_TRIG_OFF = 8'h10; // soft_trigger_reg.
	localparam logic [7:0] PENDING_OFF = 8'h14; // pending_reg, write one to clear.
	// ----------------------------------------------------------------
	// Reset values and bus answers
	// ----------------------------------------------------------------
	localparam logic [23:0] LINE_RESET = 24'h000000; // Every per-line register.
	localparam logic [1:0] RESP_OKAY = 2'h0; // Access accepted.
	localparam logic [1:0] RESP_SLVERR = 2'h2; // Unmapped offset.
endpackage : elec_pkg
`default_nettype wire
